// ===== aqsf_top.sv
// Status register of a two-queue conversion scheduler with Wishbone access.
// Assumes queue engine events are single-cycle pulses on clk_i.
`timescale 1ns/1ps
module aqsf_top
	import aqsf_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic [AQSF_AW-1:0] adr_i,
	input wire logic [3:0] sel_i,
	input wire logic [31:0] dat_i,
	output logic [31:0] dat_o,
	output logic ack_o,
	input wire logic stop_i,
	input wire logic freeze_i,
	input wire logic q1_last_done_i,
	input wire logic q2_last_done_i,
	input wire logic q1_pause_done_i,
	input wire logic q2_pause_done_i,
	input wire logic q1_gate_early_i,
	input wire logic q1_trigger_i,
	input wire logic q2_trigger_i,
	input wire logic q1_gate_eoq2_i,
	input wire logic q1_active_i,
	input wire logic q1_paused_i,
	input wire logic q2_active_i,
	input wire logic q2_paused_i,
	input wire logic q2_pending_i,
	input wire logic ptr_load_i,
	input wire logic [5:0] ptr_i,
	output logic q1_done_irq_o,
	output logic q1_pause_irq_o,
	output logic q2_done_irq_o,
	output logic q2_pause_irq_o
);
	typedef struct packed {
		aqsf_bus_t bus;
		logic [31:0] dat;
		logic [3:0] en;
		logic [5:0] ptr;
		logic [3:0] irq;
		logic q1_busy;
		logic q2_busy;
		logic ack;
	} aqsf_top_t;
	aqsf_top_t r;
	aqsf_top_t next_r;
	logic [5:0] flag_set;
	logic [5:0] flag_clr;
	logic [5:0] flags;
	logic [3:0] qs;
	logic wr_status;
	logic wr_enable;
	logic [15:0] status_word;
	logic q1_done_set;
	logic q2_done_set;

	// Stop resets every flag as a clear that nothing can override
	logic flag_rst;
	assign flag_rst = rst_i | stop_i;

	assign q1_done_set = q1_last_done_i;
	assign q2_done_set = q2_last_done_i;

	// Flag order: done1 pause1 done2 pause2 tor1 tor2
	always_comb begin
		flag_set[5] = q1_done_set;
		flag_set[4] = q1_pause_done_i | q1_gate_early_i;
		flag_set[3] = q2_done_set;
		flag_set[2] = q2_pause_done_i;
		// Overrun from an active, unfinished queue, or for queue 1 from the eoq2 gate while active; execution is untouched
		flag_set[1] = (q1_active_i & r.q1_busy & q1_trigger_i)
			| (q1_active_i & q1_gate_eoq2_i);
		flag_set[0] = q2_active_i & r.q2_busy & q2_trigger_i;
	end

	assign wr_status = (r.bus == AQSF_BUS_IDLE) & cyc_i & stb_i & we_i
		& (adr_i == AQSF_STATUS_OFF);
	assign wr_enable = (r.bus == AQSF_BUS_IDLE) & cyc_i & stb_i & we_i
		& (adr_i == AQSF_ENABLE_OFF);

	always_comb begin
		flag_clr = '0;
		if (wr_status & sel_i[1]) begin
			// Ones are ignored, zeros clear
			flag_clr[5] = ~dat_i[AQSF_DONE1_BIT];
			flag_clr[4] = ~dat_i[AQSF_PAUSE1_BIT];
			flag_clr[3] = ~dat_i[AQSF_DONE2_BIT];
			flag_clr[2] = ~dat_i[AQSF_PAUSE2_BIT];
			flag_clr[1] = ~dat_i[AQSF_TOR1_BIT];
			flag_clr[0] = ~dat_i[AQSF_TOR2_BIT];
		end
	end

	genvar gi;
	generate
		for (gi = 0; gi < 6; gi++) begin : g_flag
			aqsf_sticky u_flag (
				.clk_i(clk_i),
				.rst_i(flag_rst),
				.set_i(flag_set[gi]),
				.clr_i(flag_clr[gi]),
				.flag_o(flags[gi])
			);
		end
	endgenerate

	aqsf_qstate u_qstate (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.stop_i(stop_i),
		.freeze_i(freeze_i),
		.q1_active_i(q1_active_i),
		.q1_paused_i(q1_paused_i),
		.q2_active_i(q2_active_i),
		.q2_paused_i(q2_paused_i),
		.q2_pending_i(q2_pending_i),
		.qs_o(qs)
	);

	always_comb begin
		status_word = '0;
		status_word[AQSF_DONE1_BIT] = flags[5];
		status_word[AQSF_PAUSE1_BIT] = flags[4];
		status_word[AQSF_DONE2_BIT] = flags[3];
		status_word[AQSF_PAUSE2_BIT] = flags[2];
		status_word[AQSF_TOR1_BIT] = flags[1];
		status_word[AQSF_TOR2_BIT] = flags[0];
		status_word[AQSF_QS_LSB +: 4] = qs;
		status_word[AQSF_PTR_LSB +: 6] = r.ptr;
	end

	always_comb begin
		next_r = r;
		// Busy marks a scan that has started and not yet completed or paused
		if (q1_last_done_i | q1_pause_done_i | !q1_active_i) begin
			next_r.q1_busy = 1'b0;
		end else if (q1_trigger_i) begin
			next_r.q1_busy = 1'b1;
		end
		if (q2_last_done_i | q2_pause_done_i | !q2_active_i) begin
			next_r.q2_busy = 1'b0;
		end else if (q2_trigger_i) begin
			next_r.q2_busy = 1'b1;
		end
		// Pointer has no bus write path
		if (stop_i) begin
			next_r.ptr = AQSF_PTR_RESET;
		end else if (ptr_load_i & !freeze_i) begin
			next_r.ptr = ptr_i;
		end
		if (stop_i) begin
			next_r.en = AQSF_EN_RESET;
		end else if (wr_enable & sel_i[0]) begin
			next_r.en = dat_i[3:0];
		end
		next_r.irq[3] = flags[5] & r.en[AQSF_EN_DONE1_BIT];
		next_r.irq[2] = flags[4] & r.en[AQSF_EN_PAUSE1_BIT];
		next_r.irq[1] = flags[3] & r.en[AQSF_EN_DONE2_BIT];
		next_r.irq[0] = flags[2] & r.en[AQSF_EN_PAUSE2_BIT];
		// Ack kept as its own flop so the pin carries no decode logic
		next_r.ack = 1'b0;
		case (r.bus)
			AQSF_BUS_IDLE: begin
				if (cyc_i & stb_i) begin
					next_r.bus = AQSF_BUS_ACK;
					next_r.ack = 1'b1;
					next_r.dat = '0;
					if (!we_i) begin
						if (adr_i == AQSF_STATUS_OFF) begin
							next_r.dat = {16'h0000, status_word};
						end else if (adr_i == AQSF_ENABLE_OFF) begin
							next_r.dat = {28'h0000000, r.en};
						end
					end
				end
			end
			AQSF_BUS_ACK: begin
				next_r.bus = AQSF_BUS_IDLE;
			end
			default: begin
				next_r.bus = AQSF_BUS_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			r <= '0;
		end else begin
			r <= next_r;
		end
	end

	assign dat_o = r.dat;
	assign ack_o = r.ack;
	assign q1_done_irq_o = r.irq[3];
	assign q1_pause_irq_o = r.irq[2];
	assign q2_done_irq_o = r.irq[1];
	assign q2_pause_irq_o = r.irq[0];
endmodule // aqsf_top

// ===== aqsf_pkg.sv
// Package for the queue status flag block: register map, field layout, codes.
// Assumes a 32-bit classic Wishbone slave port with word-aligned registers.
package aqsf_pkg;
	localparam int AQSF_AW = 4;
	localparam logic [AQSF_AW-1:0] AQSF_STATUS_OFF = 4'h0;
	localparam logic [AQSF_AW-1:0] AQSF_ENABLE_OFF = 4'h4;
	localparam int AQSF_DONE1_BIT = 15;
	localparam int AQSF_PAUSE1_BIT = 14;
	localparam int AQSF_DONE2_BIT = 13;
	localparam int AQSF_PAUSE2_BIT = 12;
	localparam int AQSF_TOR1_BIT = 11;
	localparam int AQSF_TOR2_BIT = 10;
	localparam int AQSF_QS_LSB = 6;
	localparam int AQSF_PTR_LSB = 0;
	localparam int AQSF_EN_DONE1_BIT = 0;
	localparam int AQSF_EN_PAUSE1_BIT = 1;
	localparam int AQSF_EN_DONE2_BIT = 2;
	localparam int AQSF_EN_PAUSE2_BIT = 3;
	localparam logic [3:0] AQSF_QS_RESET = 4'h0;
	localparam logic [5:0] AQSF_PTR_RESET = 6'h00;
	localparam logic [3:0] AQSF_EN_RESET = 4'h0;
	// Queue 2 sub-codes within the joint state field
	localparam logic [1:0] AQSF_Q2_IDLE = 2'h0;
	localparam logic [1:0] AQSF_Q2_PAUSED = 2'h1;
	localparam logic [1:0] AQSF_Q2_RUN = 2'h2;
	localparam logic [1:0] AQSF_Q2_PEND = 2'h3;
	// Queue 1 sub-codes
	localparam logic [1:0] AQSF_Q1_IDLE = 2'h0;
	localparam logic [1:0] AQSF_Q1_PAUSED = 2'h1;
	localparam logic [1:0] AQSF_Q1_RUN = 2'h2;
	typedef enum logic [1:0] {
		AQSF_BUS_IDLE,
		AQSF_BUS_ACK
	} aqsf_bus_t;
endpackage

// ===== aqsf_sticky.sv
// One sticky flag: hardware set wins over a software clear by zero.
// Assumes set and clear are single-cycle pulses on the same clock.
`timescale 1ns/1ps
module aqsf_sticky
	import aqsf_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic set_i,
	input wire logic clr_i,
	output logic flag_o
);
	typedef struct packed {
		logic flag;
	} aqsf_sticky_t;
	aqsf_sticky_t r;
	aqsf_sticky_t next_r;
	always_comb begin
		next_r = r;
		if (set_i) begin
			next_r.flag = 1'b1;
		end else if (clr_i) begin
			next_r.flag = 1'b0;
		end
	end
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			r <= '0;
		end else begin
			r <= next_r;
		end
	end
	assign flag_o = r.flag;
endmodule // aqsf_sticky

// ===== aqsf_qstate.sv
// Joint queue state field encoder, held during freeze and cleared in stop.
// Assumes per-queue state inputs come from the queue engine on this clock.
`timescale 1ns/1ps
module aqsf_qstate
	import aqsf_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic stop_i,
	input wire logic freeze_i,
	input wire logic q1_active_i,
	input wire logic q1_paused_i,
	input wire logic q2_active_i,
	input wire logic q2_paused_i,
	input wire logic q2_pending_i,
	output logic [3:0] qs_o
);
	typedef struct packed {
		logic [3:0] qs;
	} aqsf_qstate_t;
	aqsf_qstate_t r;
	aqsf_qstate_t next_r;
	logic [1:0] q1;
	logic [1:0] q2;
	always_comb begin
		q1 = AQSF_Q1_IDLE;
		q2 = AQSF_Q2_IDLE;
		if (q1_active_i) begin
			q1 = AQSF_Q1_RUN;
		end else if (q1_paused_i) begin
			q1 = AQSF_Q1_PAUSED;
		end
		// Queue 2 code ignores queue 1; pending outranks running, which outranks paused
		if (q2_pending_i) begin
			q2 = AQSF_Q2_PEND;
		end else if (q2_active_i) begin
			q2 = AQSF_Q2_RUN;
		end else if (q2_paused_i) begin
			q2 = AQSF_Q2_PAUSED;
		end
		next_r = r;
		if (stop_i) begin
			next_r.qs = AQSF_QS_RESET;
		end else if (!freeze_i) begin
			next_r.qs = {q1, q2};
		end
	end
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			r <= '0;
		end else begin
			r <= next_r;
		end
	end
	assign qs_o = r.qs;
endmodule // aqsf_qstate

// ===== aqsf_props.sv
// Checker for the queue status block, bound to its top module.
// Assumes one clock and a master that holds each request until ack.
`timescale 1ns/1ps
module aqsf_props
	import aqsf_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic [AQSF_AW-1:0] adr_i,
	input wire logic [3:0] sel_i,
	input wire logic [31:0] dat_i,
	input wire logic [31:0] dat_o,
	input wire logic ack_o,
	input wire logic stop_i,
	input wire logic q1_last_done_i,
	input wire logic q2_last_done_i,
	input wire logic q2_pause_done_i,
	input wire logic q1_done_irq_o,
	input wire logic q1_pause_irq_o,
	input wire logic q2_done_irq_o,
	input wire logic q2_pause_irq_o
);
	logic [3:0] en;
	wire t = cyc_i && stb_i && !ack_o;
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	// Shadow of the enable register; stop clears it like the real one
	always_ff @(posedge clk_i) begin
		if (rst_i || stop_i)
			en <= 4'h0;
		else if (t && we_i && adr_i == AQSF_ENABLE_OFF && sel_i[0])
			en <= dat_i[3:0];
	end
	sequence s_clr(int b);
		t && we_i && adr_i == AQSF_STATUS_OFF && sel_i[1] && !dat_i[b];
	endsequence
	sequence s_run;
		!stop_i ##1 !stop_i;
	endsequence
	property p_ack;
		t |=> ack_o ##1 !ack_o;
	endproperty
	a_ack: assert property (p_ack) else $error("ack is not a single pulse");
	property p_done;
		(q1_last_done_i && en[0]) ##0 s_run |=> q1_done_irq_o;
	endproperty
	a_done: assert property (p_done) else $error("done request missing");
	property p_pause;
		(q2_pause_done_i && en[3]) ##0 s_run |=> q2_pause_irq_o;
	endproperty
	a_pause: assert property (p_pause) else $error("pause request missing");
	property p_gate;
		!en[1] && !$past(en[1]) |-> !q1_pause_irq_o;
	endproperty
	a_gate: assert property (p_gate) else $error("pause request while disabled");
	property p_clr;
		s_clr(15) ##0 !q1_last_done_i |=> ##1 !q1_done_irq_o;
	endproperty
	a_clr: assert property (p_clr) else $error("done request not cleared");
	property p_win;
		s_clr(13) ##0 (q2_last_done_i && en[2]) ##0 s_run |=> q2_done_irq_o;
	endproperty
	a_win: assert property (p_win) else $error("clear beat a set");
	property p_stop;
		stop_i [*2] |=> !(q1_done_irq_o || q1_pause_irq_o || q2_done_irq_o || q2_pause_irq_o);
	endproperty
	a_stop: assert property (p_stop) else $error("request alive in stop");
	property p_hi;
		t && !we_i |=> dat_o[31:16] == 16'h0000;
	endproperty
	a_hi: assert property (p_hi) else $error("upper read bits set");
endmodule // aqsf_props

bind aqsf_top aqsf_props u_props (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i,
	.dat_i, .dat_o, .ack_o, .stop_i, .q1_last_done_i, .q2_last_done_i, .q2_pause_done_i,
	.q1_done_irq_o, .q1_pause_irq_o, .q2_done_irq_o, .q2_pause_irq_o);

// ===== testbench.sv
// Self-checking bench for the queue status block over Wishbone.
// Assumes a one-cycle ack and single-edge event pulses.
`timescale 1ns/1ps
module testbench
	import aqsf_pkg::*;
;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0, stop_i = 1'b0, freeze_i = 1'b0;
	logic [AQSF_AW-1:0] adr_i = '0;
	logic [3:0] sel_i = 4'h0;
	logic [31:0] dat_i = 32'h0, dat_o, r;
	logic ack_o;
	logic [8:0] ev = 9'h000;
	logic [4:0] qlv = 5'h00;
	logic [5:0] ptr = 6'h00;
	logic [3:0] irq;
	int n_errors = 0, cmp_count = 0, cyc_cnt = 0;
	aqsf_top dut_u (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i, .dat_o,
		.ack_o, .stop_i, .freeze_i, .q1_last_done_i(ev[0]), .q1_pause_done_i(ev[1]),
		.q2_last_done_i(ev[2]), .q2_pause_done_i(ev[3]), .q1_gate_early_i(ev[4]),
		.q1_trigger_i(ev[5]), .q2_trigger_i(ev[6]), .q1_gate_eoq2_i(ev[7]),
		.ptr_load_i(ev[8]), .ptr_i(ptr), .q1_active_i(qlv[4]), .q1_paused_i(qlv[3]),
		.q2_active_i(qlv[2]), .q2_paused_i(qlv[1]), .q2_pending_i(qlv[0]),
		.q1_done_irq_o(irq[3]), .q1_pause_irq_o(irq[2]), .q2_done_irq_o(irq[1]),
		.q2_pause_irq_o(irq[0]));
	always #4 clk_i = ~clk_i;
	task final_report();
		if (n_errors == 0 && cmp_count > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			n_errors++;
			$display("Error at %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task wb(input logic w, input logic [3:0] a, input logic [31:0] d, input logic [3:0] s);
		cyc_i <= 1'b1;
		stb_i <= 1'b1;
		we_i <= w;
		adr_i <= a;
		dat_i <= d;
		sel_i <= s;
		do @(posedge clk_i); while (ack_o !== 1'b1);
		r = dat_o;
		cyc_i <= 1'b0;
		stb_i <= 1'b0;
		@(posedge clk_i);
	endtask
	task rd(input logic [3:0] a, input logic [31:0] e);
		wb(1'b0, a, 32'h0, 4'hF);
		chk(r, e);
	endtask
	task pl(input logic [8:0] v);
		ev <= v;
		@(posedge clk_i);
		ev <= 9'h000;
		@(posedge clk_i);
	endtask
	// Hang guard, far above the few hundred cycles the sequence needs
	always @(posedge clk_i) begin
		cyc_cnt <= cyc_cnt + 1;
		if (cyc_cnt == 3000) begin
			n_errors++;
			final_report();
		end
	end
	initial begin
		repeat (8) @(posedge clk_i);
		rst_i <= 1'b0;
		rd(AQSF_STATUS_OFF, 32'h0);
		wb(1'b1, 4'h8, 32'hFFFF_FFFF, 4'hF);
		rd(4'h8, 32'h0);
		rd(AQSF_ENABLE_OFF, 32'h0);
		wb(1'b1, AQSF_ENABLE_OFF, 32'hF, 4'h1);
		pl(9'h00F);
		rd(AQSF_STATUS_OFF, 32'hF000);
		chk({28'h0, irq}, 32'hF);
		wb(1'b1, AQSF_STATUS_OFF, 32'hFFFF, 4'h3);
		rd(AQSF_STATUS_OFF, 32'hF000);
		for (int i = 15; i >= 12; i--) begin
			wb(1'b1, AQSF_STATUS_OFF, ~(32'h1 << i), 4'h2);
			rd(AQSF_STATUS_OFF, 32'hF000 & ~(32'hFFFF << i));
		end
		chk({28'h0, irq}, 32'h0);
		wb(1'b1, AQSF_ENABLE_OFF, 32'hD, 4'h1);
		pl(9'h003);
		rd(AQSF_STATUS_OFF, 32'hC000);
		chk({28'h0, irq}, 32'h8);
		wb(1'b1, AQSF_STATUS_OFF, 32'h0, 4'h2);
		ev <= 9'h004;
		fork
			wb(1'b1, AQSF_STATUS_OFF, 32'h0, 4'h2);
			begin @(posedge clk_i); ev <= 9'h000; end
		join
		rd(AQSF_STATUS_OFF, 32'h2000);
		wb(1'b1, AQSF_STATUS_OFF, 32'h0, 4'h2);
		qlv <= 5'h10;
		pl(9'h020);
		pl(9'h020);
		rd(AQSF_STATUS_OFF, 32'h0A00);
		wb(1'b1, AQSF_STATUS_OFF, 32'h0, 4'h2);
		pl(9'h080);
		rd(AQSF_STATUS_OFF, 32'h0A00);
		pl(9'h001);
		qlv <= 5'h00;
		wb(1'b1, AQSF_STATUS_OFF, 32'hF7FF, 4'h2);
		pl(9'h020);
		pl(9'h020);
		rd(AQSF_STATUS_OFF, 32'h8000);
		pl(9'h010);
		rd(AQSF_STATUS_OFF, 32'hC000);
		wb(1'b1, AQSF_STATUS_OFF, 32'h0, 4'h2);
		qlv <= 5'h04;
		pl(9'h040);
		pl(9'h040);
		rd(AQSF_STATUS_OFF, 32'h0480);
		wb(1'b1, AQSF_STATUS_OFF, 32'h0, 4'h2);
		for (int i = 0; i < 12; i++) begin
			qlv <= {i[3:2] == 2, i[3:2] == 1, i[1:0] == 2, i[1:0] == 1, i[1:0] == 3};
			@(posedge clk_i);
			rd(AQSF_STATUS_OFF, i << 6);
		end
		qlv <= 5'h10;
		ptr <= 6'h3F;
		pl(9'h100);
		rd(AQSF_STATUS_OFF, 32'h023F);
		wb(1'b1, AQSF_STATUS_OFF, 32'h0, 4'h1);
		rd(AQSF_STATUS_OFF, 32'h023F);
		freeze_i <= 1'b1;
		qlv <= 5'h00;
		ptr <= 6'h15;
		pl(9'h100);
		rd(AQSF_STATUS_OFF, 32'h023F);
		freeze_i <= 1'b0;
		pl(9'h00F);
		stop_i <= 1'b1;
		qlv <= 5'h10;
		repeat (2) @(posedge clk_i);
		rd(AQSF_STATUS_OFF, 32'h0);
		stop_i <= 1'b0;
		qlv <= 5'h00;
		rd(AQSF_ENABLE_OFF, 32'h0);
		chk({28'h0, irq}, 32'h0);
		final_report();
	end
endmodule // testbench
